// ===== rtl/timer_pkg.sv
// Package with register indices, field positions and reset values of the timer control block.
package timer_pkg;

  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int CNT_W = 16;
  localparam int MAX_CHAN = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CHAN_MODE = 6'h00;
  localparam logic [IDX_W-1:0] IDX_FORCE = 6'h01;
  localparam logic [IDX_W-1:0] IDX_CNT_HI = 6'h04;
  localparam logic [IDX_W-1:0] IDX_CNT_LO = 6'h05;
  localparam logic [IDX_W-1:0] IDX_SYS_CTL = 6'h06;
  localparam logic [IDX_W-1:0] IDX_TOGGLE = 6'h07;
  localparam logic [IDX_W-1:0] IDX_FINE_PRE = 6'h08;
  localparam logic [IDX_W-1:0] IDX_OVF_MASK = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_CHAN_MASK = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_SYS_CTL2 = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_CHAN_FLAG = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_OVF_FLAG = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_CHAN_BASE = 6'h10;
  localparam logic [IDX_W-1:0] IDX_CHAN_LAST = 6'h1F;
  localparam logic [IDX_W-1:0] IDX_ACC_HI = 6'h22;
  localparam logic [IDX_W-1:0] IDX_ACC_LO = 6'h23;

  // Field positions in the system control register.
  localparam int SYS_ENABLE_BIT = 7;
  localparam int SYS_ACC_EN_BIT = 6;
  localparam int FREEZE_STOP_BIT = 5;
  localparam int FAST_CLR_BIT = 4;
  localparam int PREC_SEL_BIT = 3;
  // Overflow flag and its mask sit in bit 7 of their registers.
  localparam int OVF_BIT = 7;
  localparam int LEGACY_PRE_W = 3;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [CNT_W-1:0] RESET_WORD = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

endpackage : timer_pkg

// ===== rtl/timer_flag_prescale_overflow_ctrl.sv
// Timer control block: freeze stop, fast flag clear, prescale select and overflow toggle.
//
// Local design decision: the APB interface to the registers.
module timer_flag_prescale_overflow_ctrl #(
  parameter int NUM_CHAN = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic freeze_mode,
  input wire logic [NUM_CHAN-1:0] capture_in,
  input wire logic pulse_in,
  output logic [NUM_CHAN-1:0] compare_out,
  output logic irq
);

  if (NUM_CHAN < 1 || NUM_CHAN > timer_pkg::MAX_CHAN) begin : g_bad_chan
    $error("NUM_CHAN must lie between 1 and 8");
  end

  function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic low);
    pick_byte = low ? word[7:0] : word[15:8];
  endfunction : pick_byte

  function automatic logic is_mapped(input logic [timer_pkg::IDX_W-1:0] idx);
    logic hit;
    hit = 1'b0;
    if (idx == timer_pkg::IDX_CHAN_MODE || idx == timer_pkg::IDX_FORCE ||
        idx == timer_pkg::IDX_CNT_HI || idx == timer_pkg::IDX_CNT_LO ||
        idx == timer_pkg::IDX_SYS_CTL || idx == timer_pkg::IDX_TOGGLE ||
        idx == timer_pkg::IDX_FINE_PRE || idx == timer_pkg::IDX_OVF_MASK ||
        idx == timer_pkg::IDX_CHAN_MASK || idx == timer_pkg::IDX_SYS_CTL2 ||
        idx == timer_pkg::IDX_CHAN_FLAG || idx == timer_pkg::IDX_OVF_FLAG ||
        idx == timer_pkg::IDX_ACC_HI || idx == timer_pkg::IDX_ACC_LO) begin
      hit = 1'b1;
    end
    if (idx >= timer_pkg::IDX_CHAN_BASE && idx <= timer_pkg::IDX_CHAN_LAST) begin
      hit = 1'b1;
    end
    is_mapped = hit;
  endfunction : is_mapped

  // Synchronisers for pins from outside the clock domain.
  logic frz_s1_reg, frz_s2_reg;
  logic [NUM_CHAN-1:0] cap_s1_reg, cap_s2_reg, cap_d_reg;
  logic pulse_s1_reg, pulse_s2_reg, pulse_d_reg;

  // Software-visible state.
  logic enable_reg, acc_en_reg, freeze_stop_ctl_reg, fast_flag_clear_ctl_reg;
  logic precision_select_reg, prec_locked_reg;
  logic [timer_pkg::LEGACY_PRE_W-1:0] legacy_prescale_reg;
  logic [7:0] fine_prescale_reg;
  logic [NUM_CHAN-1:0] chan_mode_reg;
  logic [NUM_CHAN-1:0] overflow_toggle_enable_reg;
  logic [NUM_CHAN-1:0] chan_mask_reg;
  logic ovf_mask_reg;
  logic [NUM_CHAN-1:0] channel_event_flag_reg;
  logic overflow_flag_reg;
  logic [timer_pkg::CNT_W-1:0] chan_val_reg [NUM_CHAN];
  logic [timer_pkg::CNT_W-1:0] counter_value_reg;
  logic [7:0] presc_cnt_reg;
  logic [timer_pkg::CNT_W-1:0] accum_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // Bus decode.
  logic [timer_pkg::IDX_W-1:0] idx;
  logic bad_addr, setup_phase, access_ok, wr, rd, is_chan, chan_low;
  logic [2:0] chan_num;
  logic [7:0] wdat;
  logic [7:0] rd_byte;

  assign idx = paddr[timer_pkg::ADDR_W-1:2];
  assign bad_addr = !is_mapped(idx) || (paddr[1:0] != 2'b00);
  assign setup_phase = psel && !penable;
  assign access_ok = psel && penable && !bad_addr;
  assign wr = access_ok && pwrite && pstrb[0];
  assign rd = access_ok && !pwrite;
  assign wdat = pwdata[7:0];
  assign is_chan = (idx >= timer_pkg::IDX_CHAN_BASE) && (idx <= timer_pkg::IDX_CHAN_LAST);
  assign chan_num = idx[3:1];
  assign chan_low = idx[0];

  // The slave never waits, so every access completes in two cycles.
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // Prescaler and counter timing.
  logic frz_stop, run, tick, ovf_event;
  logic [7:0] div_last;
  logic [NUM_CHAN-1:0] match_event, capture_event, force_req;
  logic [NUM_CHAN-1:0] fast_clr_chan, w1c_chan;
  logic fast_clr_ovf, w1c_ovf;

  assign frz_stop = frz_s2_reg && freeze_stop_ctl_reg;
  assign run = enable_reg && !frz_stop;

  always_comb begin
    if (precision_select_reg) begin
      div_last = fine_prescale_reg;
    end else begin
      div_last = 8'((9'h001 << legacy_prescale_reg) - 9'h001);
    end
  end

  assign tick = run && (presc_cnt_reg >= div_last);
  assign ovf_event = tick && (counter_value_reg == timer_pkg::CNT_MAX);

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      match_event[i] = tick && chan_mode_reg[i] &&
                       (16'(counter_value_reg + 16'h0001) == chan_val_reg[i]);
      capture_event[i] = !chan_mode_reg[i] && cap_s2_reg[i] && !cap_d_reg[i];
      force_req[i] = wr && (idx == timer_pkg::IDX_FORCE) && wdat[i] && chan_mode_reg[i];
      w1c_chan[i] = wr && (idx == timer_pkg::IDX_CHAN_FLAG) && wdat[i];
      // Reading a capture or writing a compare clears only with fast clear on.
      fast_clr_chan[i] = fast_flag_clear_ctl_reg && is_chan && (32'(chan_num) == i) &&
                         ((rd && !chan_mode_reg[i]) || (wr && chan_mode_reg[i]));
    end
  end

  assign w1c_ovf = wr && (idx == timer_pkg::IDX_OVF_FLAG) && wdat[timer_pkg::OVF_BIT];
  // Any access to either counter byte counts, whatever the strobes say.
  assign fast_clr_ovf = fast_flag_clear_ctl_reg && access_ok &&
                        (idx == timer_pkg::IDX_CNT_HI || idx == timer_pkg::IDX_CNT_LO);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frz_s1_reg <= 1'b0;
      frz_s2_reg <= 1'b0;
      cap_s1_reg <= '0;
      cap_s2_reg <= '0;
      cap_d_reg <= '0;
      pulse_s1_reg <= 1'b0;
      pulse_s2_reg <= 1'b0;
      pulse_d_reg <= 1'b0;
    end else begin
      frz_s1_reg <= freeze_mode;
      frz_s2_reg <= frz_s1_reg;
      cap_s1_reg <= capture_in;
      cap_s2_reg <= cap_s1_reg;
      cap_d_reg <= cap_s2_reg;
      pulse_s1_reg <= pulse_in;
      pulse_s2_reg <= pulse_s1_reg;
      pulse_d_reg <= pulse_s2_reg;
    end
  end

  // System control; precision select takes only the first write after reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_reg <= 1'b0;
      acc_en_reg <= 1'b0;
      freeze_stop_ctl_reg <= 1'b0;
      fast_flag_clear_ctl_reg <= 1'b0;
      precision_select_reg <= 1'b0;
      prec_locked_reg <= 1'b0;
    end else if (wr && idx == timer_pkg::IDX_SYS_CTL) begin
      enable_reg <= wdat[timer_pkg::SYS_ENABLE_BIT];
      acc_en_reg <= wdat[timer_pkg::SYS_ACC_EN_BIT];
      freeze_stop_ctl_reg <= wdat[timer_pkg::FREEZE_STOP_BIT];
      fast_flag_clear_ctl_reg <= wdat[timer_pkg::FAST_CLR_BIT];
      if (!prec_locked_reg) begin
        precision_select_reg <= wdat[timer_pkg::PREC_SEL_BIT];
      end
      prec_locked_reg <= 1'b1;
    end
  end

  // Plain configuration registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      legacy_prescale_reg <= '0;
      fine_prescale_reg <= timer_pkg::RESET_BYTE;
      chan_mode_reg <= '0;
      overflow_toggle_enable_reg <= '0;
      chan_mask_reg <= '0;
      ovf_mask_reg <= 1'b0;
    end else if (wr) begin
      unique case (idx)
        timer_pkg::IDX_SYS_CTL2: legacy_prescale_reg <= wdat[timer_pkg::LEGACY_PRE_W-1:0];
        timer_pkg::IDX_FINE_PRE: fine_prescale_reg <= wdat;
        timer_pkg::IDX_CHAN_MODE: chan_mode_reg <= wdat[NUM_CHAN-1:0];
        // Bits above the channel count are simply not stored.
        timer_pkg::IDX_TOGGLE: overflow_toggle_enable_reg <= wdat[NUM_CHAN-1:0];
        timer_pkg::IDX_CHAN_MASK: chan_mask_reg <= wdat[NUM_CHAN-1:0];
        timer_pkg::IDX_OVF_MASK: ovf_mask_reg <= wdat[timer_pkg::OVF_BIT];
        default: ;
      endcase
    end
  end

  // Prescale divider and main counter; both stand still while frozen with freeze stop set.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_cnt_reg <= timer_pkg::RESET_BYTE;
      counter_value_reg <= timer_pkg::RESET_WORD;
    end else if (run) begin
      if (tick) begin
        presc_cnt_reg <= timer_pkg::RESET_BYTE;
        counter_value_reg <= 16'(counter_value_reg + 16'h0001);
      end else begin
        presc_cnt_reg <= 8'(presc_cnt_reg + 8'h01);
      end
    end
  end

  // The accumulator ignores freeze entirely, so emulation stops never lose pulses.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accum_reg <= timer_pkg::RESET_WORD;
    end else if (acc_en_reg && pulse_s2_reg && !pulse_d_reg) begin
      accum_reg <= 16'(accum_reg + 16'h0001);
    end
  end

  // Channel value registers: capture wins over a software write in the same cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_val_reg[i] <= timer_pkg::RESET_WORD;
      end
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (capture_event[i]) begin
          chan_val_reg[i] <= counter_value_reg;
        end else if (wr && is_chan && 32'(chan_num) == i) begin
          if (chan_low) begin
            chan_val_reg[i][7:0] <= wdat;
          end else begin
            chan_val_reg[i][15:8] <= wdat;
          end
        end
      end
    end
  end

  // Sticky flags: a new event in the clearing cycle keeps the flag set.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_event_flag_reg <= '0;
      overflow_flag_reg <= 1'b0;
    end else begin
      channel_event_flag_reg <= (channel_event_flag_reg & ~(w1c_chan | fast_clr_chan)) |
                                capture_event | match_event;
      overflow_flag_reg <= (overflow_flag_reg && !(w1c_ovf || fast_clr_ovf)) ||
                           ovf_event;
    end
  end

  // Output compare pins; the overflow toggle suppresses a forced action.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compare_out <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (chan_mode_reg[i]) begin
          if (ovf_event && overflow_toggle_enable_reg[i]) begin
            compare_out[i] <= !compare_out[i];
          end else if (force_req[i] || match_event[i]) begin
            compare_out[i] <= !compare_out[i];
          end
        end
      end
    end
  end

  assign irq = |(channel_event_flag_reg & chan_mask_reg) || (overflow_flag_reg && ovf_mask_reg);

  // Read multiplexer.
  always_comb begin
    rd_byte = timer_pkg::RESET_BYTE;
    unique case (idx)
      timer_pkg::IDX_CHAN_MODE: rd_byte = 8'(chan_mode_reg);
      timer_pkg::IDX_CNT_HI: rd_byte = pick_byte(counter_value_reg, 1'b0);
      timer_pkg::IDX_CNT_LO: rd_byte = pick_byte(counter_value_reg, 1'b1);
      timer_pkg::IDX_SYS_CTL: begin
        rd_byte[timer_pkg::SYS_ENABLE_BIT] = enable_reg;
        rd_byte[timer_pkg::SYS_ACC_EN_BIT] = acc_en_reg;
        rd_byte[timer_pkg::FREEZE_STOP_BIT] = freeze_stop_ctl_reg;
        rd_byte[timer_pkg::FAST_CLR_BIT] = fast_flag_clear_ctl_reg;
        rd_byte[timer_pkg::PREC_SEL_BIT] = precision_select_reg;
      end
      timer_pkg::IDX_TOGGLE: rd_byte = 8'(overflow_toggle_enable_reg);
      timer_pkg::IDX_FINE_PRE: rd_byte = fine_prescale_reg;
      timer_pkg::IDX_OVF_MASK: rd_byte[timer_pkg::OVF_BIT] = ovf_mask_reg;
      timer_pkg::IDX_CHAN_MASK: rd_byte = 8'(chan_mask_reg);
      timer_pkg::IDX_SYS_CTL2: rd_byte = 8'(legacy_prescale_reg);
      timer_pkg::IDX_CHAN_FLAG: rd_byte = 8'(channel_event_flag_reg);
      timer_pkg::IDX_OVF_FLAG: rd_byte[timer_pkg::OVF_BIT] = overflow_flag_reg;
      timer_pkg::IDX_ACC_HI: rd_byte = pick_byte(accum_reg, 1'b0);
      timer_pkg::IDX_ACC_LO: rd_byte = pick_byte(accum_reg, 1'b1);
      default: begin
        for (int i = 0; i < NUM_CHAN; i++) begin
          if (is_chan && 32'(chan_num) == i) begin
            rd_byte = pick_byte(chan_val_reg[i], chan_low);
          end
        end
      end
    endcase
  end

  // Read data and error are captured in the setup cycle and stand through the access.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= (bad_addr || pwrite) ? 32'h00000000 : {24'h000000, rd_byte};
      pslverr_reg <= bad_addr;
    end
  end

endmodule : timer_flag_prescale_overflow_ctrl

// ===== test/timer_ctrl_props.sv
// Checker for the bus answers and output pins of the timer control block.
module timer_ctrl_props #(
  parameter int NUM_CHAN = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic freeze_mode,
  input wire logic [NUM_CHAN-1:0] capture_in,
  input wire logic pulse_in,
  input wire logic [NUM_CHAN-1:0] compare_out,
  input wire logic irq
);
  logic [5:0] idx;
  logic setup;
  logic wr_acc;
  logic lock_reg;
  logic lock_val_reg;
  logic [NUM_CHAN-1:0] tog_reg;
  assign idx = paddr[7:2];
  assign setup = psel && !penable && !pwrite && paddr[1:0] == 2'h0;
  assign wr_acc = psel && penable && pwrite && pstrb[0] && paddr[1:0] == 2'h0;
  // Only the first control write after reset may set the precision choice.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_reg <= 1'b0;
      lock_val_reg <= 1'b0;
    end else if (wr_acc && idx == timer_pkg::IDX_SYS_CTL && !lock_reg) begin
      lock_reg <= 1'b1;
      lock_val_reg <= pwdata[timer_pkg::PREC_SEL_BIT];
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_reg <= '0;
    end else if (wr_acc && idx == timer_pkg::IDX_TOGGLE) begin
      tog_reg <= pwdata[NUM_CHAN-1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ready_high; pready; endproperty
  property p_misaligned; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr; endproperty
  property p_unmapped; setup && idx inside {6'h02, 6'h03, 6'h09, 6'h0A} |=> pslverr; endproperty
  property p_err_zero; pslverr |-> prdata == 32'h0; endproperty
  property p_upper_zero; setup |=> prdata[31:8] == 24'h0; endproperty
  property p_hold; !(psel && !penable) |=> $stable(prdata) && $stable(pslverr); endproperty
  property p_tog_read; setup && idx == timer_pkg::IDX_TOGGLE |=> prdata == 32'(tog_reg); endproperty
  property p_lock;
    setup && idx == timer_pkg::IDX_SYS_CTL && lock_reg |=> prdata[3] == lock_val_reg;
  endproperty
  property p_reset_quiet; $rose(rst_b) |-> compare_out == '0 && !irq && !pslverr; endproperty
  a_ready_high: assert property (p_ready_high) else $error("pready low");
  a_misaligned: assert property (p_misaligned) else $error("misaligned not refused");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_tog_read: assert property (p_tog_read) else $error("toggle readback wrong");
  a_lock: assert property (p_lock) else $error("precision select changed");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  c_tog: cover property (setup && idx == timer_pkg::IDX_TOGGLE);
  c_irq: cover property ($rose(irq));
  c_pin: cover property ($changed(compare_out));
endmodule : timer_ctrl_props

bind timer_flag_prescale_overflow_ctrl timer_ctrl_props #(.NUM_CHAN(NUM_CHAN)) u_props (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .freeze_mode(freeze_mode), .capture_in(capture_in),
  .pulse_in(pulse_in), .compare_out(compare_out), .irq(irq));

// ===== test/apb_cpu.sv
// Register bus master that stands in for the processor.
module apb_cpu (
  input wire logic clk,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0,
  output logic [3:0] pstrb = 4'hF,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // The data bus is inverted on release so a stale word never looks fresh.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer
endmodule : apb_cpu

// ===== test/timer_flag_prescale_overflow_ctrl_tb.sv
// Self-checking bench for the timer control block.
module timer_flag_prescale_overflow_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic freeze_mode = 1'b0;
  logic pulse_in = 1'b0;
  logic [3:0] capture_in = 4'h0;
  logic psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0] pstrb, compare_out;
  int fails = 0;
  int cmp_count = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  apb_cpu cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  timer_flag_prescale_overflow_ctrl DUT (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .freeze_mode(freeze_mode),
    .capture_in(capture_in), .pulse_in(pulse_in), .compare_out(compare_out), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    cmp_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("ERROR %0t count step %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : rng
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    cpu.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, e);
  endtask : rdc
  // Two counter reads whose setup edges lie 40 clocks apart.
  task automatic rate(input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] first;
    cpu.xfer(1'b0, 8'h14, 32'h0, rd, er);
    first = rd[7:0];
    repeat (37) @(posedge clk);
    cpu.xfer(1'b0, 8'h14, 32'h0, rd, er);
    rng(8'(rd[7:0] - first), lo, hi);
  endtask : rate
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask : do_reset
  task automatic t_regs;
    rdc(8'h1C, 32'h0);
    wr(8'h1C, 32'hFF);
    rdc(8'h1C, 32'h0F);
    cpu.xfer(1'b0, 8'h08, 32'h0, rd, er);
    chk(32'(er), 32'h1);
    cpu.xfer(1'b1, 8'h1D, 32'hFF, rd, er);
    chk(32'(er), 32'h1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_prec;
    wr(8'h20, 32'h03);
    wr(8'h34, 32'h07);
    wr(8'h18, 32'h88);
    rate(8'h09, 8'h0B);
    wr(8'h18, 32'h80);
    rdc(8'h18, 32'h88);
    rate(8'h09, 8'h0B);
    $display("t_prec done");
  endtask : t_prec
  task automatic t_legacy;
    wr(8'h34, 32'h02);
    wr(8'h18, 32'h80);
    rate(8'h09, 8'h0B);
    wr(8'h34, 32'h00);
    rate(8'h27, 8'h29);
    $display("t_legacy done");
  endtask : t_legacy
  task automatic t_freeze;
    wr(8'h18, 32'hE0);
    freeze_mode <= 1'b1;
    repeat (4) @(posedge clk);
    cpu.xfer(1'b0, 8'h14, 32'h0, rd, er);
    v = rd;
    repeat (3) begin
      pulse_in <= 1'b1;
      repeat (3) @(posedge clk);
      pulse_in <= 1'b0;
      repeat (3) @(posedge clk);
    end
    rdc(8'h14, v);
    rdc(8'h8C, 32'h03);
    wr(8'h18, 32'hC0);
    rate(8'h27, 8'h29);
    freeze_mode <= 1'b0;
    $display("t_freeze done");
  endtask : t_freeze
  task automatic t_ovf;
    int n;
    wr(8'h00, 32'h01);
    wr(8'h1C, 32'h05);
    wr(8'h2C, 32'h80);
    wr(8'h30, 32'h04);
    capture_in[2] <= 1'b1;
    repeat (5) @(posedge clk);
    // The capture came little more than a hundred counts after reset, so its high byte is zero.
    rdc(8'h50, 32'h00);
    rdc(8'h38, 32'h04);
    n = 0;
    while (compare_out === 4'h0 && n < 70000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    chk(32'(compare_out), 32'h1);
    wr(8'h04, 32'h05);
    @(posedge clk);
    chk(32'(compare_out), 32'h0);
    // The counter wrapped a few cycles ago, so its high byte still reads zero.
    rdc(8'h10, 32'h00);
    rdc(8'h3C, 32'h80);
    wr(8'h18, 32'hD0);
    rdc(8'h10, 32'h00);
    rdc(8'h3C, 32'h00);
    chk(32'(irq), 32'h1);
    rdc(8'h50, 32'h00);
    // The wrap also matched channel 0, whose compare value is zero.
    rdc(8'h38, 32'h01);
    wr(8'h40, 32'h00);
    rdc(8'h38, 32'h00);
    chk(32'(irq), 32'h0);
    $display("t_ovf done");
  endtask : t_ovf
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_prec();
    do_reset();
    t_legacy();
    t_freeze();
    t_ovf();
    finish_test();
  end
  // One full counter wrap at divide-by-one dominates the run; the rest is a few hundred.
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule : timer_flag_prescale_overflow_ctrl_tb
